//--- core/bdvc_pkg.sv
package bdvc_pkg;

  localparam int NDVC = 3;
  localparam int NCONV = 4;

  // Register map
  localparam logic [7:0] ADDR_MODE_A = 8'h2C;
  localparam logic [7:0] ADDR_MODE_B = 8'h2D;
  localparam logic [7:0] ADDR_VCORE  = 8'h2E;
  localparam logic [7:0] ADDR_VPROC  = 8'h2F;
  localparam logic [7:0] ADDR_VMEM   = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h31;

  // Field positions
  localparam int VCODE_LSB   = 0;
  localparam int VCODE_W     = 6;
  localparam int EN_BIT      = 6;
  localparam int CONF_BIT    = 7;
  localparam int MODE_LO_LSB = 0;
  localparam int ILIM_LO_LSB = 2;
  localparam int MODE_HI_LSB = 4;
  localparam int ILIM_HI_LSB = 6;

  // Reset values
  localparam logic [7:0] RST_MODE_A = 8'h11;
  localparam logic [7:0] RST_MODE_B = 8'h11;
  localparam logic [7:0] RST_VREG   = 8'h00;

  typedef enum logic [1:0] {
    OP_SLEEP     = 2'h0,
    OP_AUTO      = 2'h1,
    OP_SYNC      = 2'h2,
    OP_AUTO_SYNC = 2'h3
  } bdvc_op_t;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_TIME_NS  = 1000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int SOFTSTART_US  = 200;
  localparam int SOFTSTART_CYCLES = (SOFTSTART_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Voltage scale, in microvolts
  localparam int VMIN_UV      = 500000;
  localparam int VCODE_STEP_UV = 25000;
  localparam int RAMP_STEP_UV = 6250;
  localparam int VLOW_UV      = 725000;
  localparam int SUBSTEPS     = VCODE_STEP_UV / RAMP_STEP_UV;
  localparam logic [5:0] VLOW_CODE = 6'((VLOW_UV - VMIN_UV) / VCODE_STEP_UV);

  typedef logic [3:0][11:0] bdvc_ilim_tbl_t;
  localparam bdvc_ilim_tbl_t ILIM_CORE_TBL = {12'd3000, 12'd2400, 12'd2000, 12'd1600};
  localparam bdvc_ilim_tbl_t ILIM_STD_TBL  = {12'd1500, 12'd1200, 12'd1000, 12'd800};

endpackage

//--- core/bdvc_ramp.sv
`timescale 1ns/100ps
`default_nettype none
module bdvc_ramp
  import bdvc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic [5:0] goal_code,
  output logic      [7:0] level_q,
  output logic            slewing,
  output logic            low_zone
);

  logic [7:0] goal4;
  logic [7:0] thr4;
  logic [7:0] floor4;

  initial begin
    if (SUBSTEPS != 4) $error("bdvc_ramp needs four ramp steps per code");
  end

  // Level counts 6.25 mV steps above 0.500 V; code n sits at 4n
  assign goal4  = {goal_code, 2'b00}; // R20
  assign thr4   = {VLOW_CODE, 2'b00};
  assign floor4 = (goal4 < thr4) ? thr4 : goal4; // R5

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= 8'h00;
    end else if (!enable) begin
      level_q <= goal4;
    end else if (level_q <= thr4 && goal4 <= thr4) begin
      // Below threshold the rail settles with the load, no controlled slew
      level_q <= goal4; // R25
    end else if (level_q < thr4) begin
      level_q <= thr4;
    end else if (tick) begin
      if (level_q > floor4) begin
        level_q <= level_q - 8'h01; // R24
      end else if (level_q < floor4) begin
        level_q <= level_q + 8'h01; // R2
      end
    end
  end

  assign slewing  = enable && level_q >= thr4 && level_q != floor4; // R25
  assign low_zone = (goal4 < thr4) && (level_q <= thr4);

endmodule
`default_nettype wire

//--- core/bdvc_switch.sv
`timescale 1ns/100ps
`default_nettype none
module bdvc_switch #(
  parameter int SS_CYCLES = 25000
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic close_req,
  output logic      sw_on_q,
  output logic      soft_q,
  output logic      discharge_q
);

  localparam int CW = $clog2(SS_CYCLES + 1);
  logic [CW-1:0] cnt_q;

  initial begin
    // One cycle would close the switch with no limited-drive phase
    if (SS_CYCLES < 2) $error("bdvc_switch soft start needs two cycles");
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q   <= '0;
      soft_q  <= 1'b0;
      sw_on_q <= 1'b0;
    end else if (!close_req) begin
      cnt_q   <= '0;
      soft_q  <= 1'b0;
      sw_on_q <= 1'b0;
    end else if (!sw_on_q) begin
      // Limited gate drive first, full on only after the count
      if (cnt_q == CW'(SS_CYCLES - 1)) begin
        soft_q  <= 1'b0;
        sw_on_q <= 1'b1; // R18
      end else begin
        soft_q <= 1'b1;
        cnt_q  <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      discharge_q <= 1'b1;
    end else begin
      discharge_q <= !close_req; // R17
    end
  end

endmodule
`default_nettype wire

//--- core/bdvc_top.sv
// Behaviour
// R1: Host reprograms voltage targets in 25 mV steps
// R2: New targets ramp at 6.25 mV per us
// R3: Ready line asserted while any ramp runs
// R4: Below 0.725 V only pulse frequency operation
// R5: Lowering below 0.725 V: slew stops, sleep forced
// R6: Forced synchronous, forced sleep, or automatic by load
// R7: Sleep operation always regulates by pulse frequency
// R8: Core mode field first register bits 1:0
// R9: Processor mode field first register bits 5:4
// R10: Memory mode field second register bits 1:0
// R11: Peripheral mode field second register bits 5:4
// R12: Core limit 1600/2000/2400/3000 mA codes
// R13: Processor limit 800/1000/1200/1500 mA, bits 7:6
// R14: Memory limit 800/1000/1200/1500 mA, bits 3:2
// R15: Peripheral limit 800/1000/1200/1500 mA, bits 7:6
// R16: Memory and peripheral switches, sequencer controlled
// R17: Open switch enables output pull-down discharge
// R18: Closing switch passes roughly 200 us soft start
// R19: Default targets loaded from one-time store
// R20: Code 0 is 0.500 V, plus 25 mV each
// R21: Preset bit: clear ramps on go, set presets
// R22: Enable bit turns converter off or on
// R23: Reset state disables every converter
// R24: Ramp steps once per microsecond tick
// R25: Sub-threshold approach not reported as slewing
`timescale 1ns/100ps
`default_nettype none
module bdvc_top
  import bdvc_pkg::*;
#(
  parameter int SS_CYCLES = SOFTSTART_CYCLES
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_we,
  input  wire logic            reg_re,
  output logic      [7:0]      reg_rdata,
  input  wire logic [2:0]      ramp_go,
  input  wire logic [2:0]      seq_apply,
  input  wire logic            otp_load,
  input  wire logic [2:0][5:0] otp_vcode,
  input  wire logic            pd_reset,
  input  wire logic [3:0]      light_load,
  input  wire logic            fb_ready_sel,
  input  wire logic            periph_conv_enable,
  input  wire logic [1:0]      sw_close_req,
  output logic      [3:0]      conv_enable,
  output logic      [3:0]      conv_pfm,
  output logic      [3:0][11:0] conv_ilim_ma,
  output logic      [2:0][7:0] dvc_level,
  output logic                 fb_ready,
  output logic      [1:0]      sw_on,
  output logic      [1:0]      sw_soft,
  output logic      [1:0]      sw_discharge
);

  logic [7:0]      mode_a_q;
  logic [7:0]      mode_b_q;
  logic [2:0][7:0] vreg_q;
  logic [2:0][5:0] act_code_q;
  logic [2:0]      act_en_q;
  logic [6:0]      tick_cnt_q;
  logic            tick;
  logic [2:0]      slewing;
  logic [2:0]      low_zone;
  logic [3:0][1:0] op_sel;
  logic [3:0][1:0] ilim_sel;
  logic [3:0]      conv_low;
  logic [3:0]      conv_slew;
  logic [3:0]      conv_en_src;
  logic [3:0]      pfm_d;
  logic [7:0]      rdata_d;
  logic [7:0]      status;

  initial begin
    if (SS_CYCLES < 1) $error("bdvc_top soft start count too small");
    if (TICK_CYCLES > 128) $error("bdvc_top tick counter too narrow");
  end

  // Control register writes; the one-time store load overrides a write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_a_q <= RST_MODE_A;
      mode_b_q <= RST_MODE_B;
    end else if (reg_we) begin
      if (reg_addr == ADDR_MODE_A) begin
        mode_a_q <= reg_wdata; // R8
      end
      if (reg_addr == ADDR_MODE_B) begin
        mode_b_q <= reg_wdata; // R10
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vreg_q <= {NDVC{RST_VREG}};
    end else begin
      for (int i = 0; i < NDVC; i++) begin
        if (otp_load) begin
          vreg_q[i][VCODE_LSB +: VCODE_W] <= otp_vcode[i]; // R19
          vreg_q[i][CONF_BIT]             <= 1'b0;
        end else if (reg_we && reg_addr == ADDR_VCORE + 8'(i)) begin
          vreg_q[i] <= reg_wdata; // R1
        end
        if (pd_reset) begin
          vreg_q[i][EN_BIT] <= 1'b0; // R23
        end
      end
    end
  end

  // Active copies: what the analog side actually follows
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      act_code_q <= '0;
      act_en_q   <= '0;
    end else begin
      for (int i = 0; i < NDVC; i++) begin
        if (otp_load) begin
          act_code_q[i] <= otp_vcode[i]; // R19
        end else if (!vreg_q[i][CONF_BIT] && ramp_go[i]) begin
          act_code_q[i] <= vreg_q[i][VCODE_LSB +: VCODE_W]; // R21
        end else if (vreg_q[i][CONF_BIT] && seq_apply[i]) begin
          act_code_q[i] <= vreg_q[i][VCODE_LSB +: VCODE_W]; // R21
        end
        if (pd_reset) begin
          act_en_q[i] <= 1'b0; // R23
        end else if (!vreg_q[i][CONF_BIT]) begin
          act_en_q[i] <= vreg_q[i][EN_BIT]; // R22
        end else if (seq_apply[i]) begin
          act_en_q[i] <= vreg_q[i][EN_BIT]; // R21
        end
      end
    end
  end

  // Microsecond tick for the ramp generators
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 7'h01;
    end
  end

  assign tick = (tick_cnt_q == 7'(TICK_CYCLES - 1)); // R24

  for (genvar g = 0; g < NDVC; g++) begin : g_ramp
    bdvc_ramp u_ramp (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .tick      (tick),
      .enable    (act_en_q[g]),
      .goal_code (act_code_q[g]),
      .level_q   (dvc_level[g]),
      .slewing   (slewing[g]),
      .low_zone  (low_zone[g])
    );
  end

  // Field decode per converter: core, processor, memory, peripheral
  assign op_sel[0]   = mode_a_q[MODE_LO_LSB +: 2]; // R8
  assign op_sel[1]   = mode_a_q[MODE_HI_LSB +: 2]; // R9
  assign op_sel[2]   = mode_b_q[MODE_LO_LSB +: 2]; // R10
  assign op_sel[3]   = mode_b_q[MODE_HI_LSB +: 2]; // R11
  assign ilim_sel[0] = mode_a_q[ILIM_LO_LSB +: 2]; // R12
  assign ilim_sel[1] = mode_a_q[ILIM_HI_LSB +: 2]; // R13
  assign ilim_sel[2] = mode_b_q[ILIM_LO_LSB +: 2]; // R14
  assign ilim_sel[3] = mode_b_q[ILIM_HI_LSB +: 2]; // R15

  assign conv_low    = {1'b0, low_zone};
  assign conv_slew   = {1'b0, slewing};
  assign conv_en_src = {periph_conv_enable, act_en_q};

  // Mode 11 holds synchronous while ramping so the slope stays clean
  for (genvar c = 0; c < NCONV; c++) begin : g_op
    always_comb begin
      unique case (bdvc_op_t'(op_sel[c]))
        OP_SLEEP:     pfm_d[c] = 1'b1; // R6
        OP_AUTO:      pfm_d[c] = light_load[c]; // R6
        OP_SYNC:      pfm_d[c] = 1'b0; // R6
        OP_AUTO_SYNC: pfm_d[c] = light_load[c] && !conv_slew[c];
      endcase
      if (conv_low[c]) begin
        pfm_d[c] = 1'b1; // R4
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      conv_pfm    <= '0;
      conv_enable <= '0;
    end else begin
      conv_pfm    <= pfm_d; // R7
      conv_enable <= pd_reset ? 4'h0 : conv_en_src; // R23
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      conv_ilim_ma <= '0;
    end else begin
      conv_ilim_ma[0] <= ILIM_CORE_TBL[ilim_sel[0]]; // R12
      conv_ilim_ma[1] <= ILIM_STD_TBL[ilim_sel[1]]; // R13
      conv_ilim_ma[2] <= ILIM_STD_TBL[ilim_sel[2]]; // R14
      conv_ilim_ma[3] <= ILIM_STD_TBL[ilim_sel[3]]; // R15
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fb_ready <= 1'b0;
    end else begin
      fb_ready <= fb_ready_sel && (|slewing); // R3
    end
  end

  // Output switches on memory and peripheral rails
  for (genvar s = 0; s < 2; s++) begin : g_sw
    bdvc_switch #(
      .SS_CYCLES (SS_CYCLES)
    ) u_sw (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .close_req   (sw_close_req[s]), // R16
      .sw_on_q     (sw_on[s]),
      .soft_q      (sw_soft[s]),
      .discharge_q (sw_discharge[s])
    );
  end

  // Read path, one cycle latency; unmapped addresses read zero
  assign status = {2'b00, low_zone, slewing};

  always_comb begin
    unique case (reg_addr)
      ADDR_MODE_A: rdata_d = mode_a_q;
      ADDR_MODE_B: rdata_d = mode_b_q;
      ADDR_VCORE:  rdata_d = vreg_q[0];
      ADDR_VPROC:  rdata_d = vreg_q[1];
      ADDR_VMEM:   rdata_d = vreg_q[2];
      ADDR_STATUS: rdata_d = status;
      default:     rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      reg_rdata <= rdata_d;
    end
  end

  a_ready_slew: assert property ( // R3
    @(posedge clk_sys) disable iff (!rst_b)
    (fb_ready_sel && |slewing) |=> fb_ready)
    else $error("ready line low during ramp");

  a_ready_idle: assert property ( // R25
    @(posedge clk_sys) disable iff (!rst_b)
    (low_zone[0] && !slewing[1] && !slewing[2]) |=> !fb_ready)
    else $error("ready line high in low zone");

  a_low_pfm: assert property ( // R4
    @(posedge clk_sys) disable iff (!rst_b)
    low_zone[1] |=> conv_pfm[1])
    else $error("low voltage served without pulse frequency");

  a_sleep_forced: assert property ( // R8
    @(posedge clk_sys) disable iff (!rst_b)
    (mode_a_q[1:0] == 2'h0) |=> conv_pfm[0])
    else $error("forced sleep not applied");

  a_sync_forced: assert property ( // R11
    @(posedge clk_sys) disable iff (!rst_b)
    (mode_b_q[5:4] == 2'h2) |=> !conv_pfm[3])
    else $error("forced synchronous not applied");

  a_proc_limit: assert property ( // R13
    @(posedge clk_sys) disable iff (!rst_b)
    (mode_a_q[7:6] == 2'h3) ##1 $stable(mode_a_q) |-> conv_ilim_ma[1] == 12'd1500)
    else $error("processor limit decode wrong");

  a_ramp_tick: assert property ( // R24
    @(posedge clk_sys) disable iff (!rst_b)
    (slewing[0] && !tick && $stable(act_en_q[0])) |=> $stable(dvc_level[0]))
    else $error("ramp moved without a tick");

  a_ramp_step: assert property ( // R2
    @(posedge clk_sys) disable iff (!rst_b)
    (slewing[2] && tick && act_en_q[2]) |=>
      (dvc_level[2] == $past(dvc_level[2]) + 8'h01 ||
       dvc_level[2] == $past(dvc_level[2]) - 8'h01))
    else $error("ramp step not one increment");

  a_go_apply: assert property ( // R21
    @(posedge clk_sys) disable iff (!rst_b)
    (ramp_go[0] && !vreg_q[0][CONF_BIT] && !otp_load) |=>
      act_code_q[0] == $past(vreg_q[0][5:0]))
    else $error("go did not apply new target");

  a_otp_load: assert property ( // R19
    @(posedge clk_sys) disable iff (!rst_b)
    otp_load |=> (act_code_q[1] == $past(otp_vcode[1]) && !vreg_q[1][CONF_BIT]))
    else $error("default target not loaded");

  a_reset_off: assert property ( // R23
    @(posedge clk_sys) disable iff (!rst_b)
    pd_reset |=> (conv_enable == 4'h0 && act_en_q == 3'h0))
    else $error("converters left on at reset state");

  a_discharge: assert property ( // R17
    @(posedge clk_sys) disable iff (!rst_b)
    !sw_close_req[0] |=> (sw_discharge[0] && !sw_on[0]))
    else $error("open switch without discharge");

  a_soft_first: assert property ( // R18
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(sw_on[1]) |-> $past(sw_soft[1]))
    else $error("switch closed without soft start");

endmodule
`default_nettype wire

//--- tb/bdvc_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module bdvc_seq_model (
  input  wire logic       clk_sys,
  output logic      [2:0] ramp_go,
  output logic      [2:0] seq_apply,
  output logic            otp_load,
  output logic      [1:0] sw_close_req
);
  initial begin
    ramp_go = 3'h0;
    seq_apply = 3'h0;
    otp_load = 1'b0;
    sw_close_req = 2'h0;
  end

  // Pulses are one cycle wide, moved only on the falling edge
  task automatic go(input logic [2:0] sel);
    @(negedge clk_sys);
    ramp_go = sel;
    @(negedge clk_sys);
    ramp_go = 3'h0;
  endtask

  task automatic apply(input logic [2:0] sel);
    @(negedge clk_sys);
    seq_apply = sel;
    @(negedge clk_sys);
    seq_apply = 3'h0;
  endtask

  task automatic load;
    @(negedge clk_sys);
    otp_load = 1'b1;
    @(negedge clk_sys);
    otp_load = 1'b0;
  endtask

  // Standby partial power down: switches held as levels
  task automatic set_sw(input logic [1:0] close);
    @(negedge clk_sys);
    sw_close_req = close;
  endtask
endmodule
`default_nettype wire

//--- tb/buck_dvc_mode_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module buck_dvc_mode_control_test;
  import bdvc_pkg::*;
  // Short soft start keeps the run brief
  localparam int SS = 20;
  logic             clk_sys = 1'b0;
  logic             rst_b;
  logic [7:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic             reg_we;
  logic             reg_re;
  logic [7:0]       reg_rdata;
  logic [2:0]       ramp_go;
  logic [2:0]       seq_apply;
  logic             otp_load;
  logic [2:0][5:0]  otp_vcode;
  logic             pd_reset;
  logic [3:0]       light_load;
  logic             fb_ready_sel;
  logic             periph_conv_enable;
  logic [1:0]       sw_close_req;
  logic [3:0]       conv_enable;
  logic [3:0]       conv_pfm;
  logic [3:0][11:0] conv_ilim_ma;
  logic [2:0][7:0]  dvc_level;
  logic             fb_ready;
  logic [1:0]       sw_on;
  logic [1:0]       sw_soft;
  logic [1:0]       sw_discharge;
  int               n_mismatch = 0;
  int               n_checks = 0;

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  bdvc_top #(.SS_CYCLES(SS)) dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .ramp_go(ramp_go),
    .seq_apply(seq_apply), .otp_load(otp_load), .otp_vcode(otp_vcode),
    .pd_reset(pd_reset), .light_load(light_load), .fb_ready_sel(fb_ready_sel),
    .periph_conv_enable(periph_conv_enable), .sw_close_req(sw_close_req),
    .conv_enable(conv_enable), .conv_pfm(conv_pfm), .conv_ilim_ma(conv_ilim_ma),
    .dvc_level(dvc_level), .fb_ready(fb_ready), .sw_on(sw_on), .sw_soft(sw_soft),
    .sw_discharge(sw_discharge)
  );

  bdvc_seq_model seq_u (
    .clk_sys(clk_sys), .ramp_go(ramp_go), .seq_apply(seq_apply),
    .otp_load(otp_load), .sw_close_req(sw_close_req)
  );

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk_sys);
    reg_we = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge clk_sys);
    reg_re = 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  // Watches every step from level 36 up: one 6.25 mV level per tick, ready held while moving
  task automatic ramp_to(input int i, input logic [7:0] goal, input logic [7:0] stop);
    logic [7:0] prev;
    int         n;
    int         last;
    prev = dvc_level[i];
    last = 0;
    for (n = 1; n < 8000 && dvc_level[i] !== goal; n++) begin
      @(negedge clk_sys);
      if (n > 4 && dvc_level[i] !== stop && dvc_level[i] >= 8'd36) begin
        chk(16'(fb_ready), 16'h1, "ready low while slewing");
      end
      if (dvc_level[i] !== prev && prev >= 8'd36 && dvc_level[i] >= 8'd36) begin
        chk(dvc_level[i], prev < goal ? prev + 8'd1 : prev - 8'd1, "step");
        if (last != 0) chk(16'(n - last), 16'(TICK_CYCLES), "tick spacing");
        last = n;
      end
      prev = dvc_level[i];
    end
    if (dvc_level[i] !== goal) begin
      chk(dvc_level[i], goal, "ramp stuck");
      report_and_stop();
    end
  endtask

  task automatic t_reset;
    logic [7:0] d;
    chk(conv_enable, 16'h0, "enable after reset");
    chk(sw_discharge, 16'h3, "discharge after reset");
    chk(conv_ilim_ma[0], 16'd1600, "core limit reset");
    reg_rd(ADDR_MODE_A, d);
    chk(d, RST_MODE_A, "mode a reset");
    reg_rd(ADDR_MODE_B, d);
    chk(d, RST_MODE_B, "mode b reset");
    reg_rd(8'h40, d);
    chk(d, 16'h0, "unmapped read");
    reg_wr(ADDR_STATUS, 8'hFF);
    reg_rd(ADDR_STATUS, d);
    chk(d, 16'h38, "status write");
  endtask

  task automatic t_modes;
    logic [1:0] m;
    logic [7:0] d;
    reg_wr(ADDR_VCORE, 8'h14);
    reg_wr(ADDR_VPROC, 8'h14);
    reg_wr(ADDR_VMEM, 8'h14);
    seq_u.go(3'h7);
    cycles(3);
    chk(dvc_level[0], 16'd80, "level of code 20");
    chk(dvc_level[1], 16'd80, "proc level of code 20");
    for (int c = 0; c < 4; c++) begin
      m = 2'(c);
      reg_wr(ADDR_MODE_A, {m, m, m, m});
      reg_wr(ADDR_MODE_B, {m, m, m, m});
      light_load = (c == 1) ? 4'hA : 4'h5;
      cycles(2);
      chk(conv_ilim_ma[0], ILIM_CORE_TBL[c], "core limit");
      chk(conv_ilim_ma[1], ILIM_STD_TBL[c], "proc limit");
      chk(conv_ilim_ma[2], ILIM_STD_TBL[c], "mem limit");
      chk(conv_ilim_ma[3], ILIM_STD_TBL[c], "periph limit");
      chk(conv_pfm, c == 0 ? 4'hF : c == 2 ? 4'h0 : light_load, "op");
      reg_rd(ADDR_MODE_B, d);
      chk(d, {m, m, m, m}, "mode b readback");
    end
  endtask

  task automatic t_ramp;
    reg_wr(ADDR_MODE_A, 8'h22);
    reg_wr(ADDR_VCORE, 8'h54);
    cycles(2);
    chk(conv_enable[0], 16'h1, "core on");
    reg_wr(ADDR_VCORE, 8'h56);
    reg_wr(ADDR_VMEM, 8'h56);
    cycles(4);
    chk(dvc_level[0], 16'd80, "moved before go");
    seq_u.go(3'h5);
    ramp_to(0, 8'd88, 8'd88);
    chk(dvc_level[2], 16'd88, "mem ramp");
    cycles(3);
    chk(fb_ready, 16'h0, "ready after ramp");
    chk(conv_pfm[0], 16'h0, "forced sync");
    fb_ready_sel = 1'b0;
    reg_wr(ADDR_VMEM, 8'h55);
    seq_u.go(3'h4);
    cycles(20);
    chk(fb_ready, 16'h0, "ready not selected");
    fb_ready_sel = 1'b1;
    cycles(2);
    chk(fb_ready, 16'h1, "ready selected");
    cycles(600);
    chk(dvc_level[2], 16'd84, "mem ramp down");
    reg_wr(ADDR_VCORE, 8'h44);
    seq_u.go(3'h1);
    ramp_to(0, 8'd16, 8'd36);
    cycles(3);
    chk(fb_ready, 16'h0, "ready in low zone");
    chk(conv_pfm[0], 16'h1, "low zone op");
  endtask

  task automatic t_preset;
    logic [7:0] d;
    reg_wr(ADDR_VCORE, 8'h89);
    seq_u.go(3'h1);
    cycles(5);
    chk(dvc_level[0], 16'd16, "preset moved on go");
    chk(conv_enable[0], 16'h1, "preset enable early");
    seq_u.apply(3'h1);
    cycles(4);
    chk(conv_enable[0], 16'h0, "preset enable");
    chk(dvc_level[0], 16'd36, "preset level");
    otp_vcode[0] = 6'd12;
    seq_u.load();
    reg_rd(ADDR_VCORE, d);
    chk(d & 8'hBF, 16'h0C, "otp default");
  endtask

  task automatic t_switch;
    int n;
    for (int i = 0; i < 2; i++) begin
      seq_u.set_sw(2'(1 << i));
      @(negedge clk_sys);
      chk(sw_soft, 16'(1 << i), "soft start");
      chk(sw_discharge, 16'(2 >> i), "discharge closed");
      for (n = 1; n < 100 && sw_on[i] !== 1'b1; n++) @(negedge clk_sys);
      chk(16'(n >= SS - 1 && n <= SS + 1), 16'h1, "soft length");
      if (sw_on[i] !== 1'b1) report_and_stop();
      chk(sw_soft, 16'h0, "soft end");
      seq_u.set_sw(2'h0);
      @(negedge clk_sys);
      chk({sw_on, sw_discharge}, 16'h3, "opened");
    end
  endtask

  task automatic t_pd;
    reg_wr(ADDR_VPROC, 8'h54);
    periph_conv_enable = 1'b1;
    cycles(3);
    chk(conv_enable[1], 16'h1, "proc on");
    chk(conv_enable[3], 16'h1, "periph on");
    chk(conv_enable[2], 16'h1, "mem on");
    pd_reset = 1'b1;
    cycles(2);
    pd_reset = 1'b0;
    cycles(2);
    chk(conv_enable[2:0], 16'h0, "power down");
  endtask

  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    otp_vcode = '0;
    pd_reset = 1'b0;
    light_load = 4'h5;
    fb_ready_sel = 1'b1;
    periph_conv_enable = 1'b0;
    cycles(20);
    rst_b = 1'b1;
    cycles(2);
    t_reset();
    t_modes();
    t_ramp();
    t_preset();
    t_switch();
    t_pd();
    report_and_stop();
  end
endmodule
`default_nettype wire
